//--- inc/msdp_consts.svh
`ifndef MSDP_CONSTS_SVH
`define MSDP_CONSTS_SVH

// register offsets inside the register select space (low address byte)
`define MSDP_PAGE_OFS      8'hE0
`define MSDP_MAP_OFS       8'hC8
`define MSDP_PWR0_OFS      8'hB0
`define MSDP_PWR2_OFS      8'hB4

// space-mapping field positions
`define MSDP_MAP_SRAM_FETCH 0
`define MSDP_MAP_SEC_FETCH  1
`define MSDP_MAP_PRI_FETCH  2
`define MSDP_MAP_SEC_READ   3
`define MSDP_MAP_PRI_READ   4
`define MSDP_MAP_PERIPH_EN  7
`define MSDP_MAP_WR_MASK    8'h9F

// power register fields
`define MSDP_PWR0_TURBO     3
`define MSDP_PWR2_FETCH     0
`define MSDP_PWR2_READ      1
`define MSDP_PWR2_WRITE     2
`define MSDP_PWR2_ALATCH    3
`define MSDP_PWR2_RESET     4

// reset values
`define MSDP_PAGE_RST      8'h00
`define MSDP_MAP_RST       8'h0C
`define MSDP_PWR0_RST      8'h00
`define MSDP_PWR2_RST      5'h00

// standby timing: idle time in ns, clock period in ns, cycles rounded down
`define MSDP_STANDBY_NS    70
`define MSDP_CLK_NS        10
`define MSDP_STANDBY_CYC   ((`MSDP_STANDBY_NS / `MSDP_CLK_NS) < 1 ? 1 : (`MSDP_STANDBY_NS / `MSDP_CLK_NS))

`endif

//--- inc/msdp_pkg.sv
`default_nettype none

package msdp_pkg;

  // one decode product term: care masks and match values
  typedef struct packed {
    logic        used;       // term takes part in the sum
    logic [15:0] addr_care;  // 1 = address bit compared
    logic [15:0] addr_val;   // expected address bits
    logic [7:0]  page_care;  // 1 = page bit compared
    logic [7:0]  page_val;   // expected page bits
  } msdp_pterm_s;

  // everything the logic arrays see
  typedef struct packed {
    logic [15:0] addr;
    logic        fetch;
    logic        read;
    logic        write;
    logic        alatch;
    logic        reset;
    logic        power_down;
    logic [7:0]  port_a;
    logic [7:0]  port_b;
    logic [3:0]  port_c;
    logic [1:0]  port_d;
    logic [7:0]  page;
    logic [7:0]  fb_a;
    logic [7:0]  fb_b;
    logic        flash_ready;
  } msdp_array_in_s;

  // register write sequencing
  typedef enum logic [0:0] {
    MSDP_WR_IDLE,
    MSDP_WR_HOLD
  } msdp_wr_e;

endpackage

`default_nettype wire

//--- rtl/msdp_pterm_or.sv
`timescale 1ns/1ps
`default_nettype none

// sum of up to NTERM product terms over address and page bits
module msdp_pterm_or #(
  parameter int NTERM = 3
) (
  input  wire logic [15:0]                    addr,
  input  wire logic [7:0]                     page,
  input  wire msdp_pkg::msdp_pterm_s [NTERM-1:0] terms,
  output logic                                sel
);

  // each term matches when every cared-for bit equals its value
  always_comb begin
    sel = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (terms[i].used &&
          (((addr ^ terms[i].addr_val) & terms[i].addr_care) == 16'h0000) &&
          (((page ^ terms[i].page_val) & terms[i].page_care) == 8'h00)) begin
        sel = 1'b1;
      end
    end
  end

endmodule // msdp_pterm_or

`default_nettype wire

//--- rtl/msdp_decode_page.sv
`timescale 1ns/1ps
`default_nettype none
`include "msdp_consts.svh"

module msdp_decode_page #(
  parameter int PRI_N = 8,  // primary sector selects
  parameter int SEC_N = 4   // secondary sector selects
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rstn,
  input  wire logic [15:0]                          addr,
  input  wire logic                                 program_fetch_strobe,
  input  wire logic                                 read_stb,
  input  wire logic                                 write_stb,
  input  wire logic                                 addr_latch_stb,
  input  wire logic [7:0]                           wdata,
  input  wire logic                                 mod_reset_in,
  input  wire logic                                 power_down_input,
  input  wire logic [7:0]                           port_a_in,
  input  wire logic [7:0]                           port_b_in,
  input  wire logic [3:0]                           port_c_in,
  input  wire logic [1:0]                           port_d_in,
  input  wire logic [7:0]                           macrocell_group_a_feedback,
  input  wire logic [7:0]                           macrocell_group_b_feedback,
  input  wire logic                                 flash_ready,
  input  wire msdp_pkg::msdp_pterm_s [PRI_N*3-1:0]  pri_cfg,
  input  wire msdp_pkg::msdp_pterm_s [SEC_N*3-1:0]  sec_cfg,
  input  wire msdp_pkg::msdp_pterm_s [1:0]          sram_cfg,
  input  wire msdp_pkg::msdp_pterm_s [0:0]          reg_cfg,
  input  wire msdp_pkg::msdp_pterm_s [1:0]          periph_cfg,
  output var  logic [7:0]                           rdata,
  output var  logic [PRI_N-1:0]                     primary_sector_selects,
  output var  logic [SEC_N-1:0]                     secondary_sector_selects,
  output var  logic                                 sram_select,
  output var  logic                                 register_space_select,
  output var  logic [1:0]                           periph_selects,
  output var  logic [7:0]                           page_bits,
  output var  logic [7:0]                           space_mapping_control,
  output var  msdp_pkg::msdp_array_in_s             general_logic_array_in,
  output var  logic                                 array_standby
);

  localparam int STBY_CYC = `MSDP_STANDBY_CYC;

  // registers and their next values
  logic [7:0]          page_q,  page_d;   // memory_page_select
  logic [7:0]          map_q,   map_d;    // space_mapping_control
  logic [7:0]          pwr0_q,  pwr0_d;   // power_control_zero
  logic [4:0]          pwr2_q,  pwr2_d;   // power_control_two
  logic [7:0]          rdata_q, rdata_d;  // registered read data
  msdp_pkg::msdp_wr_e  wst_q,   wst_d;    // write sequencer
  logic [7:0]          wofs_q,  wofs_d;   // offset caught at write start
  logic [7:0]          wdat_q,  wdat_d;   // data caught at write start
  logic                commit;            // trailing edge of a register write

  // standby tracking
  msdp_pkg::msdp_array_in_s arr_in;       // current array inputs
  msdp_pkg::msdp_array_in_s prev_q;       // inputs one cycle ago
  logic [7:0]               idle_q, idle_d;
  logic                     stby_q, stby_d;
  logic                     changed;

  // raw decode sums and steering terms
  logic [PRI_N-1:0] pri_raw;
  logic [SEC_N-1:0] sec_raw;
  logic             sram_raw, reg_raw;
  logic [1:0]       per_raw;
  logic             pri_ok, sec_ok, sram_ok, rw_ok, hi_any, sec_any;

  // strobes as the arrays see them, after the block bits
  always_comb begin
    arr_in             = '0;
    arr_in.addr        = addr;
    arr_in.fetch       = program_fetch_strobe & ~pwr2_q[`MSDP_PWR2_FETCH];
    arr_in.read        = read_stb       & ~pwr2_q[`MSDP_PWR2_READ];
    arr_in.write       = write_stb      & ~pwr2_q[`MSDP_PWR2_WRITE];
    arr_in.alatch      = addr_latch_stb & ~pwr2_q[`MSDP_PWR2_ALATCH];
    arr_in.reset       = mod_reset_in   & ~pwr2_q[`MSDP_PWR2_RESET];
    arr_in.power_down  = power_down_input;
    arr_in.port_a      = port_a_in;
    arr_in.port_b      = port_b_in;
    arr_in.port_c      = port_c_in;
    arr_in.port_d      = port_d_in;
    arr_in.page        = page_q;
    arr_in.fb_a        = macrocell_group_a_feedback;
    arr_in.fb_b        = macrocell_group_b_feedback;
    arr_in.flash_ready = flash_ready;
  end

  // decode sums; page bits are a term of every select
  genvar g;
  generate
    for (g = 0; g < PRI_N; g++) begin : g_pri
      msdp_pterm_or #(.NTERM(3)) u_pri (
        .addr  (addr),
        .page  (page_q),
        .terms (pri_cfg[g*3 +: 3]),
        .sel   (pri_raw[g])
      );
    end
    for (g = 0; g < SEC_N; g++) begin : g_sec
      msdp_pterm_or #(.NTERM(3)) u_sec (
        .addr  (addr),
        .page  (page_q),
        .terms (sec_cfg[g*3 +: 3]),
        .sel   (sec_raw[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_per
      msdp_pterm_or #(.NTERM(1)) u_per (
        .addr  (addr),
        .page  (page_q),
        .terms (periph_cfg[g +: 1]),
        .sel   (per_raw[g])
      );
    end
  endgenerate

  msdp_pterm_or #(.NTERM(2)) u_sram (
    .addr  (addr),
    .page  (page_q),
    .terms (sram_cfg),
    .sel   (sram_raw)
  );

  msdp_pterm_or #(.NTERM(1)) u_reg (
    .addr  (addr),
    .page  (page_q),
    .terms (reg_cfg),
    .sel   (reg_raw)
  );

  // steer strobes by the mapping bits and apply priority
  always_comb begin
    // flash writes pass so that programming works in either space
    pri_ok  = (arr_in.fetch & map_q[`MSDP_MAP_PRI_FETCH]) |
              (arr_in.read  & map_q[`MSDP_MAP_PRI_READ])  | arr_in.write;
    sec_ok  = (arr_in.fetch & map_q[`MSDP_MAP_SEC_FETCH]) |
              (arr_in.read  & map_q[`MSDP_MAP_SEC_READ])  | arr_in.write;
    sram_ok = (arr_in.fetch & map_q[`MSDP_MAP_SRAM_FETCH]) |
              arr_in.read | arr_in.write;
    rw_ok   = arr_in.read | arr_in.write;
    sram_select            = sram_raw & sram_ok;
    register_space_select  = reg_raw & rw_ok;
    periph_selects         = per_raw & {2{rw_ok & map_q[`MSDP_MAP_PERIPH_EN]}};
    hi_any                 = sram_select | register_space_select | (|periph_selects);
    secondary_sector_selects = sec_raw & {SEC_N{sec_ok & ~hi_any}};
    sec_any                = |secondary_sector_selects;
    primary_sector_selects = pri_raw & {PRI_N{pri_ok & ~hi_any & ~sec_any}};
  end

  // register writes: catch at strobe start, apply at its trailing edge
  always_comb begin
    wst_d   = wst_q;
    wofs_d  = wofs_q;
    wdat_d  = wdat_q;
    commit  = 1'b0;
    page_d  = page_q;
    map_d   = map_q;
    pwr0_d  = pwr0_q;
    pwr2_d  = pwr2_q;
    rdata_d = rdata_q;
    unique case (wst_q)
      msdp_pkg::MSDP_WR_IDLE: begin
        if (write_stb && reg_raw) begin
          wst_d  = msdp_pkg::MSDP_WR_HOLD;
          wofs_d = addr[7:0];
          wdat_d = wdata;
        end
      end
      msdp_pkg::MSDP_WR_HOLD: begin
        // the new value is visible from the next bus cycle on
        if (!write_stb) begin
          wst_d  = msdp_pkg::MSDP_WR_IDLE;
          commit = 1'b1;
        end
      end
    endcase
    if (commit) begin
      unique case (wofs_q)
        `MSDP_PAGE_OFS: page_d = wdat_q;
        `MSDP_MAP_OFS:  map_d  = wdat_q & `MSDP_MAP_WR_MASK;
        `MSDP_PWR0_OFS: pwr0_d = wdat_q;
        `MSDP_PWR2_OFS: pwr2_d = wdat_q[4:0];
        default:        ;  // unmapped offsets drop the write
      endcase
    end
    // reads return the register, zero for unmapped offsets
    if (read_stb && reg_raw) begin
      unique case (addr[7:0])
        `MSDP_PAGE_OFS: rdata_d = page_q;
        `MSDP_MAP_OFS:  rdata_d = map_q;
        `MSDP_PWR0_OFS: rdata_d = pwr0_q;
        `MSDP_PWR2_OFS: rdata_d = {3'h0, pwr2_q};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // idle counter: any input change restarts it and wakes the arrays
  always_comb begin
    changed = (arr_in != prev_q);
    idle_d  = idle_q;
    if (changed) begin
      idle_d = 8'h00;
    end else if (idle_q < 8'(STBY_CYC)) begin
      idle_d = idle_q + 8'h01;
    end
    stby_d = ~pwr0_q[`MSDP_PWR0_TURBO] & (idle_d == 8'(STBY_CYC));
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      page_q  <= `MSDP_PAGE_RST;
      map_q   <= `MSDP_MAP_RST;
      pwr0_q  <= `MSDP_PWR0_RST;
      pwr2_q  <= `MSDP_PWR2_RST;
      rdata_q <= 8'h00;
      wst_q   <= msdp_pkg::MSDP_WR_IDLE;
      wofs_q  <= 8'h00;
      wdat_q  <= 8'h00;
      prev_q  <= '0;
      idle_q  <= 8'h00;
      stby_q  <= 1'b0;
    end else begin
      page_q  <= page_d;
      map_q   <= map_d;
      pwr0_q  <= pwr0_d;
      pwr2_q  <= pwr2_d;
      rdata_q <= rdata_d;
      wst_q   <= wst_d;
      wofs_q  <= wofs_d;
      wdat_q  <= wdat_d;
      prev_q  <= arr_in;
      idle_q  <= idle_d;
      stby_q  <= stby_d;
    end
  end

  assign rdata                  = rdata_q;
  assign page_bits              = page_q;
  assign space_mapping_control  = map_q;
  assign general_logic_array_in = arr_in;
  assign array_standby          = stby_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_SEP_SPACE: assert property ((map_q == 8'h0C && program_fetch_strobe && !read_stb && !write_stb &&
      pwr2_q == 5'h00 && sec_raw != '0 && !hi_any) |-> secondary_sector_selects == '0)
    else $error("secondary flash answered a fetch in separate space");
  AST_COMBINED: assert property ((map_q[2] && map_q[4] && pri_raw[0] && !hi_any && !sec_any &&
      pwr2_q == 5'h00 && (program_fetch_strobe || read_stb)) |-> primary_sector_selects[0])
    else $error("primary flash missed a fetch or read in combined space");
  AST_PAGE_WRITE: assert property (commit && wofs_q == `MSDP_PAGE_OFS |=> page_q == $past(wdat_q))
    else $error("page register did not take the written value");
  AST_PAGE_READ: assert property ((read_stb && reg_raw && addr[7:0] == 8'hE0) |=>
      rdata == $past(page_q))
    else $error("page register read returned a wrong value");
  AST_SEC_OVER_PRI: assert property (sec_any |-> primary_sector_selects == '0)
    else $error("primary select active under a secondary select");
  AST_HIGH_PRIO: assert property (hi_any |-> (primary_sector_selects == '0 &&
      secondary_sector_selects == '0))
    else $error("flash select active under sram, register or peripheral");
  // judged against the raw pins, so a wrong steering term is caught too
  AST_SRAM_GATE: assert property (sram_select |-> (sram_raw &&
      (read_stb || write_stb || (program_fetch_strobe && map_q[0]))))
    else $error("sram enabled without its decode");
  AST_PIO_OFF: assert property (!map_q[7] |-> periph_selects == 2'h0)
    else $error("peripheral select while peripheral mode is off");
  AST_MAP_ZERO: assert property (map_q[6:5] == 2'h0)
    else $error("unused mapping bits are not zero");
  AST_WAKE: assert property ((changed || pwr0_q[3]) |=> !array_standby)
    else $error("arrays in standby after a change or with turbo set");
  AST_STANDBY: assert property ((!pwr0_q[3] && !changed) [*8] |-> array_standby)
    else $error("arrays not in standby after the idle time");
  AST_BLOCK: assert property (pwr2_q[0] |-> !general_logic_array_in.fetch)
    else $error("blocked fetch strobe reached the arrays");
  AST_PAGE_FEED: assert property (commit && wofs_q == `MSDP_PAGE_OFS |=>
      general_logic_array_in.page == $past(wdat_q))
    else $error("page bits not offered to the arrays");

  COV_PAGE_WR: cover property (commit && wofs_q == `MSDP_PAGE_OFS);
  COV_SEC_WIN: cover property (sec_any && pri_raw != '0);
  COV_STANDBY: cover property ($rose(array_standby));
  COV_PIO: cover property (periph_selects != 2'h0);

endmodule // msdp_decode_page

`default_nettype wire

//--- sim/msdp_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

// mcu bus side: changes strobes at the falling edge, holds them across the sampling edge
module msdp_mcu_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  rdata,
  output var  logic [15:0] addr,
  output var  logic        fetch_stb,
  output var  logic        read_stb,
  output var  logic        write_stb,
  output var  logic        addr_latch_stb,
  output var  logic [7:0]  wdata
);
  localparam logic [7:0] REG_HI = 8'h7F;  // high address byte of the register space

  // quiet bus at time zero
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    fetch_stb = 1'b0;
    read_stb = 1'b0;
    write_stb = 1'b0;
    addr_latch_stb = 1'b0;
  end

  // released bus: strobes drop, address and data invert so no stale value lingers
  task automatic idle();
    fetch_stb = 1'b0;
    read_stb = 1'b0;
    write_stb = 1'b0;
    addr_latch_stb = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
  endtask

  // present an address with fetch and read strobes; held until idle()
  task automatic drive(input logic [15:0] a, input logic f, input logic r);
    @(negedge clk_sys);
    addr = a;
    fetch_stb = f;
    read_stb = r;
  endtask

  // register write: one cycle of strobe, then low so the write commits
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    @(negedge clk_sys);
    addr = {REG_HI, ofs};
    wdata = d;
    write_stb = 1'b1;
    @(negedge clk_sys);
    idle();
    // commit edge, which also loads the register, plus one spare edge
    repeat (2) @(negedge clk_sys);
  endtask

  // register read: one sampling edge, data taken a full cycle later
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    @(negedge clk_sys);
    addr = {REG_HI, ofs};
    read_stb = 1'b1;
    @(negedge clk_sys);
    idle();
    @(negedge clk_sys);
    d = rdata;
  endtask
endmodule  // msdp_mcu_model

`default_nettype wire

//--- sim/tb_msdp_decode_page.sv
`timescale 1ns/1ps
`default_nettype none
`include "msdp_consts.svh"

module tb_msdp_decode_page;
  logic                               clk_sys;
  logic                               rstn;
  logic [15:0]                        addr;
  logic                               fetch_stb, read_stb, write_stb, addr_latch_stb;
  logic [7:0]                         wdata, rdata, page_bits, map_q;
  logic                               mod_reset_in, power_down_input, flash_ready;
  logic [7:0]                         port_a_in, port_b_in, fb_a, fb_b;
  logic [3:0]                         port_c_in;
  logic [1:0]                         port_d_in;
  msdp_pkg::msdp_pterm_s [23:0]       pri_cfg;
  msdp_pkg::msdp_pterm_s [11:0]       sec_cfg;
  msdp_pkg::msdp_pterm_s [1:0]        sram_cfg, periph_cfg;
  msdp_pkg::msdp_pterm_s [0:0]        reg_cfg;
  logic [7:0]                         pri_sel;
  logic [3:0]                         sec_sel;
  logic                               sram_sel, reg_sel, array_standby;
  logic [1:0]                         periph_sel;
  msdp_pkg::msdp_array_in_s           gla;
  logic [7:0]                         sel_vec;     // selects packed for comparison
  logic [7:0]                         exp_q[$];    // expected results, oldest first
  logic [7:0]                         res_val;     // result handed to the monitor
  event                               res_ev;
  int                                 mismatches, n_tests, seed;
  // rows: map, address, fetch, read, expected {periph, reg, sram, sec0, pri0}
  localparam logic [33:0] DT [14] = '{
    {8'h0C, 16'hA000, 2'b10, 8'h01}, {8'h0C, 16'hA000, 2'b01, 8'h00}, {8'h0C, 16'h9000, 2'b01, 8'h02},
    {8'h0C, 16'h9000, 2'b10, 8'h01}, {8'h0C, 16'h8100, 2'b01, 8'h04}, {8'h0C, 16'h8100, 2'b10, 8'h01},
    {8'h0C, 16'h7E10, 2'b01, 8'h00}, {8'h0C, 16'h7F20, 2'b01, 8'h08}, {8'h14, 16'hA000, 2'b01, 8'h01},
    {8'h14, 16'hA000, 2'b10, 8'h01}, {8'h14, 16'h9000, 2'b01, 8'h01}, {8'h17, 16'h8100, 2'b10, 8'h04},
    {8'h17, 16'h9000, 2'b10, 8'h02}, {8'h8C, 16'h7E10, 2'b01, 8'h10}};

  // top two bits: the unconfigured selects, which must never rise
  assign sel_vec = {|sec_sel[3:1], |pri_sel[7:1], periph_sel, reg_sel, sram_sel, sec_sel[0], pri_sel[0]};

  msdp_decode_page i_msdp_decode_page (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
    .program_fetch_strobe(fetch_stb),
    .read_stb(read_stb), .write_stb(write_stb), .addr_latch_stb(addr_latch_stb), .wdata(wdata),
    .mod_reset_in(mod_reset_in), .power_down_input(power_down_input), .port_a_in(port_a_in),
    .port_b_in(port_b_in), .port_c_in(port_c_in), .port_d_in(port_d_in), .macrocell_group_a_feedback(fb_a),
    .macrocell_group_b_feedback(fb_b), .flash_ready(flash_ready), .pri_cfg(pri_cfg), .sec_cfg(sec_cfg),
    .sram_cfg(sram_cfg), .reg_cfg(reg_cfg), .periph_cfg(periph_cfg), .rdata(rdata),
    .primary_sector_selects(pri_sel), .secondary_sector_selects(sec_sel), .sram_select(sram_sel),
    .register_space_select(reg_sel), .periph_selects(periph_sel), .page_bits(page_bits),
    .space_mapping_control(map_q), .general_logic_array_in(gla), .array_standby(array_standby));

  msdp_mcu_model i_msdp_mcu_model (.clk_sys(clk_sys), .rdata(rdata), .addr(addr), .fetch_stb(fetch_stb),
    .read_stb(read_stb), .write_stb(write_stb), .addr_latch_stb(addr_latch_stb), .wdata(wdata));

  // free-running system clock
  always #5 clk_sys = ~clk_sys;

  // monitor: each result is judged against the oldest expectation
  always @(res_ev) begin : monitor
    logic [7:0] e;
    e = exp_q.pop_front();
    n_tests++;
    if (res_val !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, res_val, e);
    end
  end

  // note the expectation, then hand the observed value over
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    exp_q.push_back(exp);
    res_val = got;
    -> res_ev;
    #1;
  endtask

  // decode check: selects are combinational, so settle a moment before looking
  task automatic dk(input logic [15:0] a, input logic f, input logic r, input logic [7:0] e);
    i_msdp_mcu_model.drive(a, f, r);
    #1;
    chk(sel_vec, e);
    @(negedge clk_sys);
    i_msdp_mcu_model.idle();
  endtask

  // register read compared with an expectation
  task automatic rk(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] d;
    i_msdp_mcu_model.rd(ofs, d);
    chk(d, e);
  endtask

  task automatic report_and_stop();
    $display("TB: %0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 5 us
  initial begin
    #50us;
    mismatches++;
    report_and_stop();
  end

  initial begin
    logic [7:0] pv;
    int n;
    seed = 7462;
    clk_sys = 1'b0;
    rstn = 1'b0;
    {mod_reset_in, power_down_input, flash_ready} = 3'b000;
    {port_a_in, port_b_in, fb_a, fb_b} = $random(seed);
    {port_c_in, port_d_in} = 6'($random(seed));
    // one term per select: primary 8000-BFFF, secondary 8000-9FFF, sram 8000-87FF
    pri_cfg = '0;
    sec_cfg = '0;
    sram_cfg = '0;
    periph_cfg = '0;
    pri_cfg[0] = '{1'b1, 16'hC000, 16'h8000, 8'h00, 8'h00};
    sec_cfg[0] = '{1'b1, 16'hE000, 16'h8000, 8'h00, 8'h00};
    sram_cfg[0] = '{1'b1, 16'hF800, 16'h8000, 8'h00, 8'h00};
    reg_cfg[0] = '{1'b1, 16'hFF00, 16'h7F00, 8'h00, 8'h00};
    periph_cfg[0] = '{1'b1, 16'hFF00, 16'h7E00, 8'h00, 8'h00};
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    chk(page_bits, `MSDP_PAGE_RST);
    rk(`MSDP_MAP_OFS, 8'h0C);
    $display("test done: reset values");
    // random page value, read back and seen by both arrays
    pv = 8'($random(seed));
    i_msdp_mcu_model.wr(`MSDP_PAGE_OFS, pv);
    chk(page_bits, pv);
    rk(`MSDP_PAGE_OFS, pv);
    chk(gla.page, pv);
    @(negedge clk_sys);
    sram_cfg[1] = '{1'b1, 16'hFFFF, 16'h4000, 8'hFF, pv};
    dk(16'h4000, 1'b0, 1'b1, 8'h04);
    i_msdp_mcu_model.wr(`MSDP_PAGE_OFS, pv ^ 8'h01);
    dk(16'h4000, 1'b0, 1'b1, 8'h00);
    $display("test done: page register");
    // mapping modes, overlap priority and peripheral mode
    for (int i = 0; i < 14; i++) begin
      i_msdp_mcu_model.wr(`MSDP_MAP_OFS, DT[i][33:26]);
      dk(DT[i][25:10], DT[i][9], DT[i][8], DT[i][7:0]);
    end
    i_msdp_mcu_model.wr(`MSDP_MAP_OFS, 8'hFF);
    rk(`MSDP_MAP_OFS, 8'h9F);
    chk(map_q, 8'h9F);
    i_msdp_mcu_model.wr(`MSDP_MAP_OFS, 8'h0C);
    $display("test done: decode");
    // array inputs are carried through
    chk(gla.port_a, port_a_in);
    chk(gla.fb_b, fb_b);
    chk(gla.addr[15:8], addr[15:8]);
    // read strobe blocked: only fetch reaches decode and arrays
    i_msdp_mcu_model.wr(`MSDP_PWR2_OFS, 8'h02);
    i_msdp_mcu_model.drive(16'h8100, 1'b1, 1'b1);
    #1;
    chk(sel_vec, 8'h01);
    chk({6'h00, gla.fetch, gla.read}, 8'h02);
    @(negedge clk_sys);
    i_msdp_mcu_model.idle();
    i_msdp_mcu_model.wr(`MSDP_PWR2_OFS, 8'h00);
    $display("test done: strobe blocking");
    // standby after a quiet spell, wake on change, none in turbo
    n = 0;
    while (array_standby !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, array_standby}, 8'h01);
    port_a_in = ~port_a_in;
    @(negedge clk_sys);
    chk({7'h00, array_standby}, 8'h00);
    i_msdp_mcu_model.wr(`MSDP_PWR0_OFS, 8'h08);
    repeat (12) @(negedge clk_sys);
    chk({7'h00, array_standby}, 8'h00);
    $display("test done: standby");
    report_and_stop();
  end
endmodule  // tb_msdp_decode_page

`default_nettype wire
